// ### design/sms_map.svh
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices and address width
// ----------------------------------------------------------------------------
`define SMS_IDX_DATA      8'h21
`define SMS_IDX_CONTROL   8'h22
`define SMS_IDX_STATUS    8'h23
`define SMS_IDX_POWER     8'h24
`define SMS_ADDR_W        10

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define SMS_CR_IRQ_EN     7
`define SMS_CR_PORT_EN    6
`define SMS_CR_HALF_BYP   5
`define SMS_CR_MASTER     4
`define SMS_CR_IDLE_LVL   3
`define SMS_CR_CAPT_EDGE  2
`define SMS_CR_RATE_HI    1
`define SMS_CR_RATE_LO    0
`define SMS_CR_RESET      8'h00

// ----------------------------------------------------------------------------
// Status fields and power fields
// ----------------------------------------------------------------------------
`define SMS_SR_DONE       7
`define SMS_SR_WRITE_COLLISION_FLAG       6
`define SMS_SR_MODE_FAULT_FLAG       4
`define SMS_PW_HALT       0
`define SMS_PW_GMASK      1
`define SMS_PW_RESET      8'h02

// ----------------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------------
`define SMS_BITS_PER_BYTE 4'h8
`define SMS_DIV_W         7

`endif

// ### design/sms_pkg.sv
package sms_pkg;

  typedef enum logic [1:0] {
    SMS_IDLE  = 2'b00,
    SMS_LEAD  = 2'b01,
    SMS_TRAIL = 2'b11
  } sms_state_t;

endpackage

// ### design/sms_port.sv
// Functional notes
// - Untouched slave echoes previously received byte.
// - Wait state leaves port running; events wake.
// - Halt freezes shift, flag and control registers; no own wakeup.
// - Both events share one gated interrupt.
// - Interrupt enable bit requests on done or fault.
// - Port enable bit; cleared by reset, fault.
// - Bit 5 bypasses extra divide-by-two stage for rate bits 00 and 10.
// - Master bit drives clock; cleared on fault.
// - Bit 3 sets serial clock idle level.
// - Bit 2 selects first or second capture edge.
// - Six master rates from divider and rate bits.
// - Done flag set at end; status then data clears.
// - Data writes ignored while done flag set.
// - Write during shifting sets collision flag.
// - Collision clears by status then data read.
// - Select low in master sets fault flag.
// - Port and master bits refused while fault.
// - Master transfer starts only on data write.
// - Received byte copied to read buffer.
// - Data write loads shift register directly.
// - Eight clocks, MSB first, full duplex.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "sms_map.svh"

module sms_port (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // Avalon-MM slave
  input  wire logic [`SMS_ADDR_W-1:0]  avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [3:0]              avs_byteenable_in,
  input  wire logic [31:0]             avs_writedata_in,
  output logic      [31:0]             avs_readdata_out,
  output logic                         avs_waitrequest_out,
  output logic      [1:0]              avs_response_out,
  // Serial clock pin
  input  wire logic                    sck_in,
  output logic                         sck_out,
  output logic                         sck_oe_n_out,
  // Master-out data pin
  input  wire logic                    mosi_in,
  output logic                         mosi_out,
  output logic                         mosi_oe_n_out,
  // Master-in data pin
  input  wire logic                    miso_in,
  output logic                         miso_out,
  output logic                         miso_oe_n_out,
  // Select input
  input  wire logic                    ss_n_in,
  // Processor side
  output logic                         irq_out,
  output logic                         wake_out
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [`SMS_ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic        ack_q;
  logic        req;
  logic        rd_acc;
  logic        wr_acc;
  logic        lane0;
  logic [7:0]  wdata;

  assign req   = (avs_read_in | avs_write_in) & ~ack_q;
  assign lane0 = avs_byteenable_in[0];
  assign wdata = avs_writedata_in[7:0];
  assign rd_acc = req & avs_read_in;
  assign wr_acc = req & avs_write_in & lane0;
  assign avs_waitrequest_out = ~ack_q;

  logic acc_data_rd;
  logic acc_data_wr;
  logic acc_ctl_wr;
  logic acc_stat;
  logic acc_pw_wr;

  assign acc_data_rd = rd_acc & hit(avs_address_in, `SMS_IDX_DATA);
  assign acc_data_wr = wr_acc & hit(avs_address_in, `SMS_IDX_DATA);
  assign acc_ctl_wr  = wr_acc & hit(avs_address_in, `SMS_IDX_CONTROL);
  assign acc_stat    = req & hit(avs_address_in, `SMS_IDX_STATUS);
  assign acc_pw_wr   = wr_acc & hit(avs_address_in, `SMS_IDX_POWER);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] sck_s_q;
  logic [1:0] mosi_s_q;
  logic [1:0] miso_s_q;
  logic [1:0] ss_s_q;
  logic       sck_last_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_s_q  <= 2'h0;
      mosi_s_q <= 2'h0;
      miso_s_q <= 2'h0;
      ss_s_q   <= 2'h3;
    end else begin
      sck_s_q  <= {sck_s_q[0], sck_in};
      mosi_s_q <= {mosi_s_q[0], mosi_in};
      miso_s_q <= {miso_s_q[0], miso_in};
      ss_s_q   <= {ss_s_q[0], ss_n_in};
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] ctl_q, pw_q, rxbuf_q, shift_q;
  logic [3:0] bitcnt_q;
  logic       done_q, write_collision_flag_q, mode_fault_flag_q, done_arm_q, write_collision_flag_arm_q, mode_fault_flag_arm_q;
  logic       out_bit_q, sck_q;
  logic       busy, run, master, enabled, fault_ev, byte_end, collide, load_ok;

  sms_pkg::sms_state_t state_q;

  assign run     = ~pw_q[`SMS_PW_HALT];
  assign master  = ctl_q[`SMS_CR_MASTER];
  assign enabled = ctl_q[`SMS_CR_PORT_EN];
  assign busy    = (state_q != sms_pkg::SMS_IDLE) | (~master & enabled & ~ss_s_q[1]);
  assign fault_ev = run & master & enabled & ~ss_s_q[1];
  assign collide = acc_data_wr & busy & ~done_q;
  assign load_ok = acc_data_wr & ~busy & ~done_q & run;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Halt and global mask are processor-side controls held in a spare register.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pw_q <= `SMS_PW_RESET;
    end else if (acc_pw_wr) begin
      pw_q <= {6'h00, wdata[1:0]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctl_q <= `SMS_CR_RESET;
    end else if (run) begin
      if (fault_ev) begin
        ctl_q[`SMS_CR_PORT_EN] <= 1'b0;
        ctl_q[`SMS_CR_MASTER]  <= 1'b0;
      end else if (acc_ctl_wr) begin
        ctl_q <= wdata;
        if (mode_fault_flag_q && !mode_fault_flag_arm_q) begin
          ctl_q[`SMS_CR_PORT_EN] <= wdata[`SMS_CR_PORT_EN] & ctl_q[`SMS_CR_PORT_EN];
          ctl_q[`SMS_CR_MASTER]  <= wdata[`SMS_CR_MASTER] & ctl_q[`SMS_CR_MASTER];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Flags and clearing sequences
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_q     <= 1'b0;
      done_arm_q <= 1'b0;
    end else if (run) begin
      if (byte_end) begin
        done_q <= 1'b1;
      end else if (done_arm_q && (acc_data_rd || acc_data_wr)) begin
        done_q <= 1'b0;
      end
      if (acc_stat && done_q) begin
        done_arm_q <= 1'b1;
      end else if (acc_data_rd || acc_data_wr || !done_q) begin
        done_arm_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_collision_flag_q     <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
    end else if (run) begin
      if (collide) begin
        write_collision_flag_q <= 1'b1;
      end else if (write_collision_flag_arm_q && acc_data_rd) begin
        write_collision_flag_q <= 1'b0;
      end
      if (acc_stat && avs_read_in) begin
        write_collision_flag_arm_q <= 1'b1;
      end else if (acc_data_rd || acc_data_wr) begin
        write_collision_flag_arm_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else if (run) begin
      if (fault_ev) begin
        mode_fault_flag_q <= 1'b1;
      end else if (mode_fault_flag_arm_q && acc_ctl_wr) begin
        mode_fault_flag_q <= 1'b0;
      end
      if (acc_stat && mode_fault_flag_q) begin
        mode_fault_flag_arm_q <= 1'b1;
      end else if (acc_ctl_wr || !mode_fault_flag_q) begin
        mode_fault_flag_arm_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Master baud divider
  // --------------------------------------------------------------------------
  function automatic logic [`SMS_DIV_W-1:0] half_period(input logic [2:0] sel);
    case (sel)
      3'h4:    half_period = 7'h01;
      3'h0:    half_period = 7'h03;
      3'h1:    half_period = 7'h07;
      3'h6:    half_period = 7'h0F;
      3'h2:    half_period = 7'h1F;
      3'h3:    half_period = 7'h3F;
      default: half_period = 7'h3F;
    endcase
  endfunction

  logic [`SMS_DIV_W-1:0] div_q;
  logic                  tick;
  logic [2:0]            rate_sel;

  assign rate_sel = {ctl_q[`SMS_CR_HALF_BYP], ctl_q[`SMS_CR_RATE_HI], ctl_q[`SMS_CR_RATE_LO]};
  assign tick = (div_q == half_period(rate_sel));

  // The clock pin flips one cycle ahead of the capture, so that a returning bit
  // that changed on the opposite edge has passed both synchroniser stages.
  logic                  sck_flip;
  assign sck_flip = master & (state_q != sms_pkg::SMS_IDLE)
                    & (div_q == half_period(rate_sel) - 7'h01);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_q <= '0;
    end else if (!run || state_q == sms_pkg::SMS_IDLE || tick) begin
      if (run) begin
        div_q <= '0;
      end
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Shift engine
  // --------------------------------------------------------------------------
  logic sck_edge;
  logic lead_edge;
  logic trail_edge;
  logic capture_edge_select;
  logic clock_idle_level;
  logic slave_act;

  assign capture_edge_select = ctl_q[`SMS_CR_CAPT_EDGE];
  assign clock_idle_level = ctl_q[`SMS_CR_IDLE_LVL];
  assign slave_act = ~master & enabled & ~ss_s_q[1];
  assign sck_edge  = (sck_s_q[1] != sck_last_q) & slave_act;
  assign lead_edge = master ? (tick & state_q == sms_pkg::SMS_LEAD)
                            : sck_edge & (sck_s_q[1] != clock_idle_level);
  assign trail_edge = master ? (tick & state_q == sms_pkg::SMS_TRAIL)
                             : sck_edge & (sck_s_q[1] == clock_idle_level);
  assign byte_end = run & trail_edge & (bitcnt_q == `SMS_BITS_PER_BYTE - 4'h1);

  logic in_bit;
  assign in_bit = master ? miso_s_q[1] : mosi_s_q[1];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_last_q <= 1'b0;
    end else if (run) begin
      sck_last_q <= sck_s_q[1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q  <= sms_pkg::SMS_IDLE;
      bitcnt_q <= 4'h0;
      shift_q  <= 8'h00;
      out_bit_q <= 1'b0;
      sck_q    <= 1'b0;
    end else if (run) begin
      if (!enabled || fault_ev) begin
        state_q  <= sms_pkg::SMS_IDLE;
        bitcnt_q <= 4'h0;
        sck_q    <= clock_idle_level;
      end else begin
        case (state_q)
          sms_pkg::SMS_IDLE: begin
            sck_q <= clock_idle_level;
            if (load_ok) begin
              shift_q   <= wdata;
              out_bit_q <= wdata[7];
              bitcnt_q  <= 4'h0;
              if (master) begin
                state_q <= sms_pkg::SMS_LEAD;
              end
            end else if (!master && slave_act) begin
              state_q <= sms_pkg::SMS_LEAD;
              out_bit_q <= shift_q[7];
            end
          end
          sms_pkg::SMS_LEAD: begin
            if (lead_edge) begin
              if (capture_edge_select) begin
                out_bit_q <= shift_q[7];
              end else begin
                shift_q <= {shift_q[6:0], in_bit};
              end
              state_q <= sms_pkg::SMS_TRAIL;
            end else if (!master && !slave_act) begin
              state_q <= sms_pkg::SMS_IDLE;
            end
          end
          sms_pkg::SMS_TRAIL: begin
            if (trail_edge) begin
              if (capture_edge_select) begin
                shift_q <= {shift_q[6:0], in_bit};
              end else begin
                out_bit_q <= shift_q[7];
              end
              bitcnt_q <= bitcnt_q + 4'h1;
              state_q  <= byte_end ? sms_pkg::SMS_IDLE : sms_pkg::SMS_LEAD;
            end else if (!master && !slave_act) begin
              state_q <= sms_pkg::SMS_IDLE;
            end
          end
          default: state_q <= sms_pkg::SMS_IDLE;
        endcase
        if (sck_flip) begin
          sck_q <= (state_q == sms_pkg::SMS_LEAD) ? ~clock_idle_level : clock_idle_level;
        end
      end
    end
  end

  // Receive buffer catches the last bit in the same cycle the done flag sets.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rxbuf_q <= 8'h00;
    end else if (byte_end) begin
      rxbuf_q <= capture_edge_select ? {shift_q[6:0], in_bit} : shift_q;
    end
  end

  // --------------------------------------------------------------------------
  // Read data, pins and interrupt
  // --------------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit(avs_address_in, `SMS_IDX_DATA)) begin
      rd_mux = rxbuf_q;
    end else if (hit(avs_address_in, `SMS_IDX_CONTROL)) begin
      rd_mux = ctl_q;
    end else if (hit(avs_address_in, `SMS_IDX_STATUS)) begin
      rd_mux = {done_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 4'h0};
    end else if (hit(avs_address_in, `SMS_IDX_POWER)) begin
      rd_mux = pw_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_response_out <= 2'h0;
    end else if (req) begin
      avs_readdata_out <= {24'h000000, rd_mux};
      avs_response_out <= 2'h0;
    end
  end

  assign sck_out       = sck_q;
  assign mosi_out      = out_bit_q;
  assign miso_out      = out_bit_q;
  assign sck_oe_n_out  = ~(enabled & master);
  assign mosi_oe_n_out = ~(enabled & master);
  assign miso_oe_n_out = ~slave_act;

  logic ev_pending;
  assign ev_pending = ctl_q[`SMS_CR_IRQ_EN] & (done_q | mode_fault_flag_q);
  assign irq_out    = ev_pending & ~pw_q[`SMS_PW_GMASK];
  assign wake_out   = irq_out & run;

endmodule

`default_nettype wire

// ### tb/sms_port_properties.sv
`timescale 1ns/100ps
`default_nettype none

module sms_port_chk (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // Register bus
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [1:0]  avs_response_out,
  // Pins
  input wire logic        sck_out,
  input wire logic        sck_oe_n_out,
  input wire logic        mosi_oe_n_out,
  input wire logic        miso_oe_n_out,
  input wire logic        ss_n_in,
  // Processor side
  input wire logic        irq_out,
  input wire logic        wake_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("Request not answered after one wait cycle.");
  property p_wait_pulse;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("Answer lasted more than one cycle.");
  property p_resp_okay;
    !avs_waitrequest_out |-> avs_response_out == 2'b00;
  endproperty
  a_resp_okay: assert property (p_resp_okay)
    else $error("Response code not okay.");
  property p_rd_upper;
    !avs_waitrequest_out && avs_read_in |-> avs_readdata_out[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("Upper read data not zero.");
  property p_wake;
    wake_out |-> irq_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Wake raised without an interrupt.");
  property p_oe_pair;
    sck_oe_n_out == mosi_oe_n_out;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("Clock and data enables differ.");
  property p_miso_excl;
    !miso_oe_n_out |-> sck_oe_n_out;
  endproperty
  a_miso_excl: assert property (p_miso_excl)
    else $error("Slave data driven while clock driven.");
  property p_miso_ss;
    ss_n_in [*4] |-> miso_oe_n_out;
  endproperty
  a_miso_ss: assert property (p_miso_ss)
    else $error("Slave data driven while not selected.");
  property p_fault;
    $fell(ss_n_in) && !sck_oe_n_out |-> ##[1:6] sck_oe_n_out;
  endproperty
  a_fault: assert property (p_fault)
    else $error("Master kept driving after select went low.");
  property p_sck_min;
    !sck_oe_n_out && $changed(sck_out) |=> $stable(sck_out);
  endproperty
  a_sck_min: assert property (p_sck_min)
    else $error("Serial clock half period below two cycles.");
endmodule

bind sms_port sms_port_chk chk_u (.clk_in, .rst_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .avs_response_out, .sck_out, .sck_oe_n_out,
  .mosi_oe_n_out, .miso_oe_n_out, .ss_n_in, .irq_out, .wake_out);

`default_nettype wire

// ### tb/sms_slave_model.sv
`timescale 1ns/100ps
`default_nettype none

module sms_slave_model (
  // Serial pins
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       sel_n_in,
  output logic            miso_out,
  // Mode and data
  input  wire logic       idle_in,
  input  wire logic       late_in,
  input  wire logic [7:0] tx_in,
  output logic      [7:0] rx_out
);
  logic [7:0] sh;
  int         cnt;

  initial begin
    miso_out = 1'b0;
    rx_out = 8'h00;
  end

  // Selection loads the byte; early capture needs the first bit out at once.
  always @(negedge sel_n_in) begin
    sh = tx_in;
    cnt = 0;
    if (!late_in) miso_out = sh[7];
  end

  // A released line shows the inverse of its last value.
  always @(posedge sel_n_in) miso_out = ~miso_out;

  // Capture edge shifts in, the other edge puts out the next bit.
  always @(sck_in) begin
    if (!sel_n_in) begin
      if ((sck_in !== idle_in) ^ late_in) begin
        sh = {sh[6:0], mosi_in};
        cnt++;
        if (cnt == 8) rx_out = sh;
      end else begin
        miso_out = sh[7];
      end
    end
  end
endmodule

`default_nettype wire

// ### tb/test_spi_master_slave_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "sms_map.svh"

module test_spi_master_slave_port;
  logic        clk_in, rst_in, avs_read_in, avs_write_in, ss_n_in, sel_n, idle, late;
  logic [9:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [1:0]  avs_response_out;
  logic        avs_waitrequest_out, sck_out, sck_oe_n_out, mosi_out, mosi_oe_n_out;
  logic        miso_out, miso_oe_n_out, irq_out, wake_out, slv_miso, sck_q;
  logic [7:0]  slv_tx, slv_rx;
  int          mismatches, samples_checked, run, half, edges;
  logic [7:0]  rate_bits [6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};
  int          rate_div [6] = '{4, 8, 16, 32, 64, 128};

  sms_port dut_u (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_byteenable_in(4'hF), .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .avs_response_out, .sck_in(sck_oe_n_out ? idle : sck_out), .sck_out, .sck_oe_n_out,
    .mosi_in(mosi_oe_n_out ? ~mosi_out : mosi_out), .mosi_out, .mosi_oe_n_out,
    .miso_in(miso_oe_n_out ? slv_miso : miso_out), .miso_out, .miso_oe_n_out, .ss_n_in,
    .irq_out, .wake_out);

  sms_slave_model slave_u (.sck_in(sck_out), .mosi_in(mosi_out), .sel_n_in(sel_n),
    .miso_out(slv_miso), .idle_in(idle), .late_in(late), .tx_in(slv_tx), .rx_out(slv_rx));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Half period of the serial clock, in system cycles, and its edge count.
  always @(posedge clk_in) begin
    if (sck_out !== sck_q) begin
      half = run;
      run = 1;
      edges++;
    end else run++;
    sck_q = sck_out;
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clk_in);
    avs_address_in <= {idx, 2'b00};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= {24'h000000, wd};
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out[7:0];
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic xfer(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] rx,
                      input int div, input logic col);
    logic [7:0] r;
    int         e;
    bus(1'b1, `SMS_IDX_CONTROL, ctl, r);
    idle <= ctl[3];
    late <= ctl[2];
    slv_tx <= rx;
    @(posedge clk_in);
    sel_n <= 1'b0;
    bus(1'b1, `SMS_IDX_DATA, tx, r);
    if (col) begin
      repeat (20) @(posedge clk_in);
      bus(1'b1, `SMS_IDX_DATA, 8'h5A, r);
    end
    wait_irq();
    chk(wake_out, 8'h01);
    chk(8'(half), 8'(div / 2));
    chk(sck_out, ctl[3]);
    chk(slv_rx, tx);
    e = edges;
    bus(1'b1, `SMS_IDX_DATA, 8'h3C, r);
    repeat (40) @(posedge clk_in);
    chk(8'(edges - e), 8'h00);
    bus(1'b0, `SMS_IDX_STATUS, 8'h00, r);
    chk(r, {1'b1, col, 6'h00});
    bus(1'b0, `SMS_IDX_DATA, 8'h00, r);
    chk(r, rx);
    bus(1'b0, `SMS_IDX_STATUS, 8'h00, r);
    chk(r, 8'h00);
    sel_n <= 1'b1;
  endtask

  task automatic report_and_stop();
    $display("Counts: checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    logic [7:0] r;
    int         e;
    mismatches = 0;
    samples_checked = 0;
    run = 0;
    half = 0;
    edges = 0;
    sck_q = 1'b0;
    rst_in = 1'b1;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 10'h000;
    avs_writedata_in = 32'h00000000;
    ss_n_in = 1'b1;
    sel_n = 1'b1;
    idle = 1'b0;
    late = 1'b0;
    slv_tx = 8'h00;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(1'b0, `SMS_IDX_CONTROL, 8'h00, r);
    chk(r, 8'h00);
    bus(1'b1, `SMS_IDX_STATUS, 8'hFF, r);
    bus(1'b0, `SMS_IDX_STATUS, 8'h00, r);
    chk(r, 8'h00);
    bus(1'b0, 8'h30, 8'h00, r);
    chk(r, 8'h00);
    bus(1'b1, `SMS_IDX_CONTROL, 8'h40, r);
    ss_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(miso_oe_n_out, 8'h00);
    ss_n_in <= 1'b1;
    $display("Test reset and slave done");
    bus(1'b1, `SMS_IDX_CONTROL, 8'hD0, r);
    ss_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    ss_n_in <= 1'b1;
    chk(irq_out, 8'h00);
    bus(1'b0, `SMS_IDX_CONTROL, 8'h00, r);
    chk(r, 8'h80);
    bus(1'b1, `SMS_IDX_CONTROL, 8'hD0, r);
    bus(1'b0, `SMS_IDX_CONTROL, 8'h00, r);
    chk(r, 8'h80);
    bus(1'b1, `SMS_IDX_POWER, 8'h00, r);
    wait_irq();
    bus(1'b0, `SMS_IDX_STATUS, 8'h00, r);
    chk(r, 8'h10);
    bus(1'b1, `SMS_IDX_CONTROL, 8'hD0, r);
    bus(1'b0, `SMS_IDX_CONTROL, 8'h00, r);
    chk(r, 8'hD0);
    bus(1'b0, `SMS_IDX_STATUS, 8'h00, r);
    chk(r, 8'h00);
    $display("Test mode fault done");
    for (int i = 0; i < 6; i++) begin
      xfer(8'hD0 | rate_bits[i] | 8'((i % 4) * 4), 8'(8'hA5 ^ i), 8'(8'h3C + i),
           rate_div[i], 1'b0);
    end
    $display("Test rates and modes done");
    xfer(8'hD3, 8'hC3, 8'h96, 128, 1'b1);
    $display("Test collision done");
    bus(1'b1, `SMS_IDX_CONTROL, 8'hD3, r);
    sel_n <= 1'b0;
    bus(1'b1, `SMS_IDX_DATA, 8'h77, r);
    repeat (100) @(posedge clk_in);
    bus(1'b1, `SMS_IDX_POWER, 8'h01, r);
    repeat (2) @(posedge clk_in);
    e = edges;
    repeat (300) @(posedge clk_in);
    chk(8'(edges - e), 8'h00);
    chk(irq_out, 8'h00);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    sel_n <= 1'b1;
    bus(1'b0, `SMS_IDX_CONTROL, 8'h00, r);
    chk(r, 8'h00);
    $display("Test halt and second reset done");
    report_and_stop();
  end

  initial begin
    #200000;
    mismatches++;
    $display("Watchdog expired");
    report_and_stop();
  end
endmodule

`default_nettype wire
